// >>> scp_pkg.sv
/*
  Constants, register map, field layout, state encoding and the
  register-state record for the serial control port and PLL
  configuration block.
  Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
package scp_pkg;

  // ==========================================================
  // Register map
  localparam int NREG = 17;
  localparam logic [15:0] REG_OFS [NREG] = '{
    16'h0300, 16'h0301, 16'h0302, 16'h0303, 16'h0304, 16'h0305,
    16'h0306, 16'h0308, 16'h0309, 16'h030A, 16'h300C, 16'h3611,
    16'h3612, 16'h3613, 16'h3614, 16'h3615, 16'h3661};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h00, 8'h2A, 8'h00, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01,
    8'h00, 8'h20, 8'h10, 8'h23, 8'h33, 8'h28, 8'h1C, 8'h6C};
  // Writable bits; the rest read back as zero
  localparam logic [7:0] REG_MSK [NREG] = '{
    8'h07, 8'h03, 8'hFF, 8'h0F, 8'h03, 8'h03, 8'h01, 8'h01, 8'h07,
    8'h01, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFE};

  // Register indices
  localparam int I_MPRE  = 0;
  localparam int I_MMULH = 1;
  localparam int I_MMULL = 2;
  localparam int I_MPOST = 3;
  localparam int I_MLINK = 4;
  localparam int I_MSPRE = 5;
  localparam int I_MSDIV = 6;
  localparam int I_MBYP  = 7;
  localparam int I_MCP   = 8;
  localparam int I_MXPRE = 9;
  localparam int I_PRI   = 10;
  localparam int I_SCTL  = 11;
  localparam int I_SCLK  = 12;
  localparam int I_SMEM  = 13;
  localparam int I_SMULL = 14;
  localparam int I_SPUMP = 15;
  localparam int I_ALT   = 16;

  // ==========================================================
  // Field positions
  localparam int P_LO    = 0;  // Low field of any register
  localparam int P_ADDR  = 1;  // 7-bit bus address
  localparam int P_HI4   = 4;  // Upper nibble
  localparam int P_SCP   = 4;  // Sys PLL charge pump
  localparam int P_SXPRE = 3;  // Sys PLL extra pre-divide
  localparam int P_BIT7  = 7;  // Bypass / pump power-down
  localparam int P_NPUMP = 4;
  localparam int P_PPUMP = 2;

  // ==========================================================
  // Bus timing and receive states
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO  = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, ST_ADDR  = 4'h1, ST_ACK_A = 4'h3,
    ST_SUBH  = 4'h2, ST_ACK_H = 4'h6, ST_SUBL  = 4'h7,
    ST_ACK_L = 4'h5, ST_WDATA = 4'h4, ST_ACK_W = 4'hC,
    ST_RDATA = 4'hB, ST_RACK  = 4'hF
  } scp_st_t;

  typedef struct packed {
    scp_st_t               st;
    logic                  scl_m, scl_s, scl_d;
    logic                  sda_m, sda_s, sda_d;
    logic                  sel_m, sel_s;
    logic [3:0]            cnt;
    logic [7:0]            sh;
    logic                  rw;
    logic                  mack;
    logic [15:0]           ptr;
    logic                  sda_oe_n;
    logic                  sda_o;
    logic [NREG-1:0][7:0]  rf;
  } scp_state_t;

  // Map a sub-address to {hit, index}
  function automatic logic [5:0] scp_decode(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFS[i] == a) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : scp_decode

  // State after the shutdown pin is released
  function automatic scp_state_t scp_rst_state();
    scp_state_t s;
    s = '0;
    s.st = ST_IDLE;
    s.scl_m = 1'b1; s.scl_s = 1'b1; s.scl_d = 1'b1;
    s.sda_m = 1'b1; s.sda_s = 1'b1; s.sda_d = 1'b1;
    s.sda_oe_n = 1'b1;
    for (int i = 0; i < NREG; i++) begin
      s.rf[i] = REG_RST[i];
    end
    return s;
  endfunction : scp_rst_state

endpackage : scp_pkg
`default_nettype wire

// >>> scp_top.sv
/*
  Serial control port slave with the PLL configuration registers.
  Assumes CLK is 200 MHz and far faster than the bus clock, that the
  bus pins are asynchronous, and that the open-drain data wire is
  resolved outside from SERIAL_DATA_LINE_OE_N.
*/
// What this block does
// - Select low: answer primary address register
// - Select high: answer alternate address register
// - Address, 16-bit sub-address high first, bytes
// - Pointer advances after every data byte
// - After address ack, drive read data
// - Bare read starts at last pointer
// - Host ack continues at next sub-address
// - Sequential writes fill incrementing sub-addresses
// - Three-bit PLL pre-divider code held
// - Ten-bit loop multiplier split across registers
// - Main post divider four-bit field
// - Link divider two bits, reset three
// - Main system pre-divider two bits
// - Main system divider, extra pre-divider bits
// - Sys PLL bypass and charge pump
// - Sys PLL extra input pre-division bit
// - System clock divider three-bit code
// - Pre, memory, converter dividers four bits
// - Pump dividers and pump power-down
// - Shutdown low restores every register default
`timescale 1ns/1ps
`default_nettype none
module scp_top (
  // Clock and shutdown reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // Two-wire bus pins
  input  wire logic        SERIAL_CLOCK_LINE,
  input  wire logic        SERIAL_DATA_LINE_IN,
  output var  logic        SERIAL_DATA_LINE_OUT,
  output var  logic        SERIAL_DATA_LINE_OE_N,
  input  wire logic        BUS_ADDRESS_SELECT_PIN,
  // Main PLL settings
  output var  logic [2:0]  MAIN_PLL_INPUT_DIVIDER,
  output var  logic [9:0]  MAIN_PLL_LOOP_MULTIPLIER,
  output var  logic [3:0]  MAIN_PLL_POST_DIVIDER,
  output var  logic [1:0]  LINK_CLOCK_DIVIDER,
  output var  logic [1:0]  MAIN_PLL_SYS_PREDIVIDER,
  output var  logic        MAIN_PLL_SYS_DIVIDER,
  output var  logic        MAIN_PLL_BYPASS,
  output var  logic [2:0]  MAIN_PLL_CHARGE_PUMP,
  output var  logic        MAIN_PLL_EXTRA_PREDIVIDER,
  // System PLL settings
  output var  logic        SYS_PLL_BYPASS,
  output var  logic [2:0]  SYS_PLL_CHARGE_PUMP,
  output var  logic        SYS_PLL_EXTRA_PREDIVIDER,
  output var  logic [2:0]  SYS_PLL_INPUT_DIVIDER,
  output var  logic        PUMP_DIVIDER_POWER_DOWN,
  output var  logic [2:0]  SYSTEM_CLOCK_DIVIDER,
  output var  logic [3:0]  SYSTEM_CLOCK_PREDIVIDER,
  output var  logic [3:0]  MEMORY_CLOCK_DIVIDER,
  output var  logic [3:0]  CONVERTER_CLOCK_DIVIDER,
  output var  logic [9:0]  SYS_PLL_LOOP_MULTIPLIER,
  output var  logic [1:0]  NEG_PUMP_DIVIDER,
  output var  logic [1:0]  POS_PUMP_DIVIDER
);
  import scp_pkg::*;

  localparam scp_state_t S_RST = scp_rst_state();

  scp_state_t s_q;
  scp_state_t s_d;

  // ==========================================================
  // Bus event decode from the synchronised pins
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [6:0] sel_addr;
  logic [5:0] dec;
  logic [7:0] rd_byte;
  logic       last_bit;

  // Edges only use the second and third stages
  assign scl_rise  = s_q.scl_s & ~s_q.scl_d;
  assign scl_fall  = ~s_q.scl_s & s_q.scl_d;
  assign bus_start = s_q.scl_s & s_q.scl_d & s_q.sda_d & ~s_q.sda_s;
  assign bus_stop  = s_q.scl_s & s_q.scl_d & ~s_q.sda_d & s_q.sda_s;
  assign last_bit  = scl_fall && (s_q.cnt == BYTE_BITS);

  // Slave address from the selected register
  assign sel_addr = s_q.sel_s ? s_q.rf[I_ALT][P_ADDR +: 7]
                              : s_q.rf[I_PRI][P_ADDR +: 7];

  // Read data at the pointer; holes read as zero
  assign dec     = scp_decode(s_q.ptr);
  assign rd_byte = dec[5] ? s_q.rf[dec[4:0]] : 8'h00;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers, then a delay stage for edges
    s_d.scl_m = SERIAL_CLOCK_LINE;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_d = s_q.scl_s;
    s_d.sda_m = SERIAL_DATA_LINE_IN;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_d = s_q.sda_s;
    s_d.sel_m = BUS_ADDRESS_SELECT_PIN;
    s_d.sel_s = s_q.sel_m;
    s_d.sda_o = 1'b0;

    // Start and stop win over any byte in flight
    if (bus_start) begin
      s_d.st       = ST_ADDR;
      s_d.cnt      = CNT_ZERO;
      s_d.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      s_d.st       = ST_IDLE;
      s_d.sda_oe_n = 1'b1;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.sda_oe_n = 1'b1;
        end
        // Receive states shift a bit on each rising clock
        ST_ADDR, ST_SUBH, ST_SUBL, ST_WDATA: begin
          if (scl_rise && s_q.cnt != BYTE_BITS) begin
            s_d.sh  = {s_q.sh[6:0], s_q.sda_s};
            s_d.cnt = s_q.cnt + 4'h1;
          end
          if (last_bit) begin
            s_d.cnt      = CNT_ZERO;
            s_d.sda_oe_n = 1'b0;  // Acknowledge by pulling low
            unique case (s_q.st)
              ST_ADDR: begin
                if (s_q.sh[7:1] == sel_addr) begin
                  s_d.st = ST_ACK_A;
                  s_d.rw = s_q.sh[0];
                end else begin
                  s_d.st       = ST_IDLE;
                  s_d.sda_oe_n = 1'b1;
                end
              end
              ST_SUBH: begin
                s_d.ptr[15:8] = s_q.sh;
                s_d.st        = ST_ACK_H;
              end
              ST_SUBL: begin
                s_d.ptr[7:0] = s_q.sh;
                s_d.st       = ST_ACK_L;
              end
              default: begin
                // Unmapped sub-addresses swallow the byte
                if (dec[5]) begin
                  s_d.rf[dec[4:0]] = s_q.sh & REG_MSK[dec[4:0]];
                end
                s_d.ptr = s_q.ptr + 16'h0001;
                s_d.st  = ST_ACK_W;
              end
            endcase
          end
        end
        // Address acknowledged: branch on direction
        ST_ACK_A: begin
          if (scl_fall) begin
            if (s_q.rw) begin
              // Pointer kept from the last transfer
              s_d.sh       = rd_byte;
              s_d.sda_oe_n = rd_byte[7];
              s_d.st       = ST_RDATA;
            end else begin
              s_d.sda_oe_n = 1'b1;
              s_d.st       = ST_SUBH;
            end
          end
        end
        ST_ACK_H: begin
          if (scl_fall) begin
            s_d.sda_oe_n = 1'b1;
            s_d.st       = ST_SUBL;
          end
        end
        // After the low sub-address or a data byte is acked the next one is data
        ST_ACK_L, ST_ACK_W: begin
          if (scl_fall) begin
            s_d.sda_oe_n = 1'b1;
            s_d.st       = ST_WDATA;
          end
        end
        // Read data changes only while the clock is low
        ST_RDATA: begin
          if (scl_rise && s_q.cnt != BYTE_BITS) begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
          if (last_bit) begin
            s_d.sda_oe_n = 1'b1;
            s_d.cnt      = CNT_ZERO;
            s_d.ptr      = s_q.ptr + 16'h0001;
            s_d.st       = ST_RACK;
          end else if (scl_fall) begin
            s_d.sh       = {s_q.sh[6:0], 1'b0};
            s_d.sda_oe_n = s_q.sh[6];
          end
        end
        // Host acknowledge: low continues, high ends the read
        ST_RACK: begin
          if (scl_rise) begin
            s_d.mack = ~s_q.sda_s;
          end
          if (scl_fall) begin
            if (s_q.mack) begin
              s_d.sh       = rd_byte;
              s_d.sda_oe_n = rd_byte[7];
              s_d.st       = ST_RDATA;
            end else begin
              s_d.st = ST_IDLE;
            end
          end
        end
        default: begin
          s_d.st       = ST_IDLE;
          s_d.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // State register; shutdown restores every default
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign SERIAL_DATA_LINE_OUT  = s_q.sda_o;
  assign SERIAL_DATA_LINE_OE_N = s_q.sda_oe_n;
  // Main PLL fields
  assign MAIN_PLL_INPUT_DIVIDER    = s_q.rf[I_MPRE][P_LO +: 3];
  assign MAIN_PLL_LOOP_MULTIPLIER  = {s_q.rf[I_MMULH][P_LO +: 2],
                                      s_q.rf[I_MMULL]};
  assign MAIN_PLL_POST_DIVIDER     = s_q.rf[I_MPOST][P_LO +: 4];
  assign LINK_CLOCK_DIVIDER        = s_q.rf[I_MLINK][P_LO +: 2];
  assign MAIN_PLL_SYS_PREDIVIDER   = s_q.rf[I_MSPRE][P_LO +: 2];
  assign MAIN_PLL_SYS_DIVIDER      = s_q.rf[I_MSDIV][P_LO];
  assign MAIN_PLL_BYPASS           = s_q.rf[I_MBYP][P_LO];
  assign MAIN_PLL_CHARGE_PUMP      = s_q.rf[I_MCP][P_LO +: 3];
  assign MAIN_PLL_EXTRA_PREDIVIDER = s_q.rf[I_MXPRE][P_LO];
  // System PLL fields
  assign SYS_PLL_BYPASS            = s_q.rf[I_SCTL][P_BIT7];
  assign SYS_PLL_CHARGE_PUMP       = s_q.rf[I_SCTL][P_SCP +: 3];
  assign SYS_PLL_EXTRA_PREDIVIDER  = s_q.rf[I_SCTL][P_SXPRE];
  assign SYS_PLL_INPUT_DIVIDER     = s_q.rf[I_SCTL][P_LO +: 3];
  assign PUMP_DIVIDER_POWER_DOWN   = s_q.rf[I_SCLK][P_BIT7];
  assign SYSTEM_CLOCK_DIVIDER      = s_q.rf[I_SCLK][P_HI4 +: 3];
  assign SYSTEM_CLOCK_PREDIVIDER   = s_q.rf[I_SCLK][P_LO +: 4];
  assign MEMORY_CLOCK_DIVIDER      = s_q.rf[I_SMEM][P_HI4 +: 4];
  assign CONVERTER_CLOCK_DIVIDER   = s_q.rf[I_SMEM][P_LO +: 4];
  assign SYS_PLL_LOOP_MULTIPLIER   = {s_q.rf[I_SPUMP][P_LO +: 2],
                                      s_q.rf[I_SMULL]};
  assign NEG_PUMP_DIVIDER          = s_q.rf[I_SPUMP][P_NPUMP +: 2];
  assign POS_PUMP_DIVIDER          = s_q.rf[I_SPUMP][P_PPUMP +: 2];

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_addr_end;
    s_q.st == ST_ADDR && last_bit && !bus_start && !bus_stop;
  endsequence
  sequence s_wr_end;
    s_q.st == ST_WDATA && last_bit && !bus_start && !bus_stop;
  endsequence
  sequence s_rd_end;
    s_q.st == ST_RDATA && last_bit && !bus_start && !bus_stop;
  endsequence

  chk_addr_match: assert property (
    s_addr_end and (s_q.sh[7:1] == sel_addr) |=>
      s_q.st == ST_ACK_A && !s_q.sda_oe_n)
    else $error("matching address not acknowledged");
  chk_addr_ignore: assert property (
    s_addr_end and (s_q.sh[7:1] != sel_addr) |=>
      s_q.st == ST_IDLE && s_q.sda_oe_n)
    else $error("foreign address acknowledged");
  chk_sub_high: assert property (
    s_q.st == ST_SUBH && last_bit && !bus_start && !bus_stop |=>
      s_q.ptr[15:8] == $past(s_q.sh) && s_q.st == ST_ACK_H)
    else $error("sub-address high byte not captured");
  chk_wr_incr: assert property (
    s_wr_end |=> s_q.ptr == $past(s_q.ptr) + 16'h0001 ##0
      s_q.st == ST_ACK_W)
    else $error("write pointer did not advance");
  chk_wr_store: assert property (
    s_wr_end and dec[5] |=>
      s_q.rf[$past(dec[4:0])] == ($past(s_q.sh) & REG_MSK[$past(dec[4:0])]))
    else $error("written byte not stored");
  chk_rd_first: assert property (
    s_q.st == ST_ACK_A && s_q.rw && scl_fall && !bus_start && !bus_stop |=>
      s_q.st == ST_RDATA && s_q.sda_oe_n == $past(rd_byte[7]))
    else $error("read data not driven after address ack");
  chk_rd_incr: assert property (
    s_rd_end |=> s_q.st == ST_RACK && s_q.sda_oe_n &&
      s_q.ptr == $past(s_q.ptr) + 16'h0001)
    else $error("read pointer did not advance");
  chk_rd_next: assert property (
    s_q.st == ST_RACK && s_q.mack && scl_fall && !bus_start && !bus_stop |=>
      s_q.st == ST_RDATA && s_q.sh == $past(rd_byte))
    else $error("acked read did not continue");
  chk_release: assert property (
    s_q.st == ST_IDLE |-> s_q.sda_oe_n)
    else $error("data line driven while idle");

  // ==========================================================
  // Frame edges, low sub-address byte and read shifting
  sequence s_subl_end;
    s_q.st == ST_SUBL && last_bit && !bus_start && !bus_stop;
  endsequence
  sequence s_rack_end;
    s_q.st == ST_RACK && scl_fall && !bus_start && !bus_stop;
  endsequence
  sequence s_rd_shift;
    s_q.st == ST_RDATA && scl_fall && !last_bit && !bus_start && !bus_stop;
  endsequence

  chk_sub_low: assert property (
    s_subl_end |=> s_q.ptr[7:0] == $past(s_q.sh) && s_q.st == ST_ACK_L && !s_q.sda_oe_n)
    else $error("sub-address low byte not captured");
  chk_start_addr: assert property (
    bus_start |=> s_q.st == ST_ADDR && s_q.cnt == CNT_ZERO && s_q.sda_oe_n)
    else $error("start did not open an address byte");
  chk_stop_idle: assert property (
    bus_stop |=> s_q.st == ST_IDLE && s_q.sda_oe_n)
    else $error("stop did not end the transfer");
  chk_wr_ack: assert property (
    s_wr_end |=> !s_q.sda_oe_n)
    else $error("written byte not acknowledged");
  chk_rd_shift: assert property (
    s_rd_shift |=> s_q.sda_oe_n == $past(s_q.sh[6]) && s_q.sh == {$past(s_q.sh[6:0]), 1'h0})
    else $error("read bit not shifted out");
  chk_rd_nack: assert property (
    s_rack_end and (!s_q.mack) |=> s_q.st == ST_IDLE && s_q.sda_oe_n)
    else $error("read went on after a host nack");
  chk_ptr_hold: assert property (
    s_q.st == ST_IDLE |=> $stable(s_q.ptr))
    else $error("pointer moved between transfers");
  chk_idle_wait: assert property (
    s_q.st == ST_IDLE && !bus_start |=> s_q.st == ST_IDLE)
    else $error("left idle without a start");
  chk_reg_quiet: assert property (
    !(s_q.st == ST_WDATA && last_bit) |=> $stable(s_q.rf))
    else $error("register changed outside a data write");
  chk_cnt_range: assert property (
    s_q.cnt <= BYTE_BITS)
    else $error("bit counter overran a byte");
  chk_ack_free: assert property (
    (s_q.st == ST_ACK_H || s_q.st == ST_ACK_L || s_q.st == ST_ACK_W) && scl_fall && !bus_start && !bus_stop
      |=> s_q.sda_oe_n && (s_q.st == ST_SUBL || s_q.st == ST_WDATA))
    else $error("acknowledge not released after the clock fell");
  chk_rx_release: assert property (
    (s_q.st == ST_ADDR || s_q.st == ST_SUBH || s_q.st == ST_SUBL || s_q.st == ST_WDATA) |-> s_q.sda_oe_n)
    else $error("data line driven while the host sends");
  chk_addr_ack_hold: assert property (
    s_q.st == ST_ACK_A |-> !s_q.sda_oe_n)
    else $error("address acknowledge dropped early");

endmodule : scp_top
`default_nettype wire

// >>> scp_host_model.sv
/*
  Bus host model: drives the bus clock and pulls the open-drain data wire.
  Assumes the bench resolves the data wire with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  // Clock
  input  wire logic CLK,
  // Bus pins
  output var  logic SCL,
  output var  logic PULL,
  input  wire logic SDA
);
  // Half bus period in CLK cycles; well above the device's sync delay
  localparam int HP = 10;

  // ==========================================================
  // Idle bus: clock high and data released, standing still
  initial begin
    SCL  = 1'b1;
    PULL = 1'b0;
  end

  // Wait n edges, then step just past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : wt

  // ==========================================================
  // Start or repeated start; data falls while the clock is high
  task automatic start();
    wt(HP / 2);
    PULL = 1'b0;
    wt(HP / 2);
    SCL = 1'b1;
    wt(HP);
    PULL = 1'b1;
    wt(HP);
    SCL = 1'b0;
  endtask : start

  // Stop; data rises while the clock is high, then the bus rests
  task automatic stop();
    wt(HP / 2);
    PULL = 1'b1;
    wt(HP / 2);
    SCL = 1'b1;
    wt(HP);
    PULL = 1'b0;
    wt(HP);
  endtask : stop

  // One bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    wt(HP / 2);
    PULL = !b;
    wt(HP / 2);
    SCL = 1'b1;
    wt(HP / 2);
    s = SDA;
    wt(HP / 2);
    SCL = 1'b0;
  endtask : bit_io

  // Byte MSB first plus acknowledge; send 8'hFF to read
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_tx, ack_rx);
  endtask : xfer
endmodule : scp_host_model
`default_nettype wire

// >>> serial_control_port_pll_config_test.sv
/*
  Self-checking bench for the serial control port and PLL registers.
  Assumes scp_pkg, scp_top and scp_host_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_control_port_pll_config_test;
  import scp_pkg::*;
  localparam int LIMIT = 80000; // Cycle ceiling for the whole run

  // ==========================================================
  // Signals
  logic       clk, nrst, sel, scl, pull, sda, oe_n, sda_out;
  logic [2:0] m_pre, m_cp, s_cp, s_pre, s_div;
  logic [9:0] m_mul, s_mul;
  logic [3:0] m_post, s_sp, s_mem, s_cnv;
  logic [1:0] m_link, m_sp, s_np, s_pp;
  logic       m_sd, m_byp, m_xp, s_byp, s_xp, s_pd;
  logic [7:0] mreg [NREG];
  logic [15:0] mptr;
  int         fail_count, comparisons, cycles;

  // Open-drain wire with pull-up; either party may pull low
  assign sda = !(pull || (!oe_n && !sda_out));

  // ==========================================================
  // Instances
  scp_top scp_top_i (
    .CLK(clk), .NRST(nrst), .SERIAL_CLOCK_LINE(scl), .SERIAL_DATA_LINE_IN(sda),
    .SERIAL_DATA_LINE_OUT(sda_out), .SERIAL_DATA_LINE_OE_N(oe_n), .BUS_ADDRESS_SELECT_PIN(sel),
    .MAIN_PLL_INPUT_DIVIDER(m_pre), .MAIN_PLL_LOOP_MULTIPLIER(m_mul), .MAIN_PLL_POST_DIVIDER(m_post),
    .LINK_CLOCK_DIVIDER(m_link), .MAIN_PLL_SYS_PREDIVIDER(m_sp), .MAIN_PLL_SYS_DIVIDER(m_sd),
    .MAIN_PLL_BYPASS(m_byp), .MAIN_PLL_CHARGE_PUMP(m_cp), .MAIN_PLL_EXTRA_PREDIVIDER(m_xp),
    .SYS_PLL_BYPASS(s_byp), .SYS_PLL_CHARGE_PUMP(s_cp), .SYS_PLL_EXTRA_PREDIVIDER(s_xp),
    .SYS_PLL_INPUT_DIVIDER(s_pre), .PUMP_DIVIDER_POWER_DOWN(s_pd), .SYSTEM_CLOCK_DIVIDER(s_div),
    .SYSTEM_CLOCK_PREDIVIDER(s_sp), .MEMORY_CLOCK_DIVIDER(s_mem), .CONVERTER_CLOCK_DIVIDER(s_cnv),
    .SYS_PLL_LOOP_MULTIPLIER(s_mul), .NEG_PUMP_DIVIDER(s_np), .POS_PUMP_DIVIDER(s_pp));

  scp_host_model host_i (.CLK(clk), .SCL(scl), .PULL(pull), .SDA(sda));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Reference model of the register file and pointer
  function automatic int m_idx(input logic [15:0] a);
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFS[i] === a) return i;
    end
    return -1;
  endfunction : m_idx

  // Unmapped places read as zero
  function automatic logic [7:0] m_rd(input logic [15:0] a);
    int i;
    i = m_idx(a);
    return (i < 0) ? 8'h00 : mreg[i];
  endfunction : m_rd

  // Selected 7-bit bus address
  function automatic logic [6:0] cur_dev();
    return sel ? mreg[I_ALT][7:1] : mreg[I_PRI][7:1];
  endfunction : cur_dev

  // ==========================================================
  // Compare tasks and closing report
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_ack(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk_ack

  task automatic chk_cfg(input string nm, input logic [37:0] e, input logic [37:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_cfg

  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Every configuration output against its register field
  task automatic chk_outs();
    chk_cfg("main_cfg", {11'h000, mreg[I_MPRE][2:0], mreg[I_MMULH][1:0], mreg[I_MMULL], mreg[I_MPOST][3:0],
      mreg[I_MLINK][1:0], mreg[I_MSPRE][1:0], mreg[I_MSDIV][0], mreg[I_MBYP][0], mreg[I_MCP][2:0],
      mreg[I_MXPRE][0]},
      {11'h000, m_pre, m_mul, m_post, m_link, m_sp, m_sd, m_byp, m_cp, m_xp});
    chk_cfg("sys_cfg", {mreg[I_SCTL], mreg[I_SCLK], mreg[I_SMEM], mreg[I_SPUMP][1:0], mreg[I_SMULL],
      mreg[I_SPUMP][5:2]},
      {s_byp, s_cp, s_xp, s_pre, s_pd, s_div, s_sp, s_mem, s_cnv, s_mul, s_np, s_pp});
  endtask : chk_outs

  // ==========================================================
  // Reset held 3 cycles, model to defaults, then the host's quiet time
  task automatic do_reset();
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    mptr = 16'h0000;
    for (int i = 0; i < NREG; i++) mreg[i] = REG_RST[i];
    repeat (8192) @(posedge clk);
    #1;
  endtask : do_reset

  // One transfer: write n random bytes, or read n bytes (set: sub-address first)
  task automatic xact(input logic [6:0] dev, input logic rd, input logic set, input logic [15:0] a, input int n);
    logic [7:0] rx, d;
    logic       ak, hit;
    int         i;
    hit = (dev === cur_dev());
    host_i.start();
    if (!rd || set) begin
      host_i.xfer({dev, 1'b0}, 1'b1, rx, ak);
      chk_ack("ack_addr_w", !hit, ak);
      if (hit) begin
        host_i.xfer(a[15:8], 1'b1, rx, ak);
        chk_ack("ack_sub_hi", 1'b0, ak);
        host_i.xfer(a[7:0], 1'b1, rx, ak);
        chk_ack("ack_sub_lo", 1'b0, ak);
        mptr = a;
      end
      if (rd) host_i.start();
    end
    if (rd) begin
      host_i.xfer({dev, 1'b1}, 1'b1, rx, ak);
      chk_ack("ack_addr_r", !hit, ak);
      for (i = 0; hit && i < n; i++) begin
        host_i.xfer(8'hFF, i == n - 1, rx, ak);
        chk_byte("rd_data", m_rd(mptr), rx);
        mptr++;
      end
    end else if (hit) begin
      repeat (n) begin
        d = 8'($urandom);
        host_i.xfer(d, 1'b1, rx, ak);
        chk_ack("ack_data", 1'b0, ak);
        i = m_idx(mptr);
        if (i >= 0) mreg[i] = d & REG_MSK[i];
        mptr++;
      end
    end
    host_i.stop();
  endtask : xact

  // ==========================================================
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    sel = 1'b0;
    void'($urandom(32'h55cf_467b));
    do_reset();
    chk_outs();
    xact(7'h10, 1'b1, 1'b1, 16'h02FF, 13);
    xact(7'h10, 1'b1, 1'b1, 16'h3611, 5);
    xact(7'h10, 1'b0, 1'b0, 16'h02FF, 13);
    xact(7'h10, 1'b0, 1'b0, 16'h3611, 5);
    chk_outs();
    xact(7'h10, 1'b1, 1'b1, 16'h02FF, 13);
    xact(7'h10, 1'b0, 1'b0, 16'h3611, 0);
    xact(7'h10, 1'b1, 1'b0, 16'h0000, 5);
    xact(7'h10, 1'b1, 1'b0, 16'h0000, 2);
    xact(7'h11, 1'b0, 1'b0, 16'h0300, 1);
    xact(7'h36, 1'b1, 1'b1, 16'h0300, 1);
    chk_outs();
    sel = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    xact(7'h10, 1'b0, 1'b0, 16'h0300, 1);
    xact(7'h36, 1'b0, 1'b0, 16'h3661, 1);
    xact(cur_dev(), 1'b1, 1'b1, 16'h3660, 3);
    sel = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    xact(7'h10, 1'b0, 1'b0, 16'h300C, 1);
    xact(cur_dev(), 1'b1, 1'b1, 16'h300C, 1);
    do_reset();
    chk_outs();
    xact(7'h10, 1'b1, 1'b1, 16'h300C, 1);
    end_sim();
  end
endmodule : serial_control_port_pll_config_test
`default_nettype wire
